// ==== include/rsc_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the reset source controller
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ==========================================================
// Register addresses
`define RSC_ADDR_SUPPLY_CTRL   8'hFF
`define RSC_ADDR_CAUSE         8'hEF

// ==========================================================
// supply_monitor_control fields
`define RSC_SMC_ON_BIT         7
`define RSC_SMC_VDD_RST_BIT    6
`define RSC_SMC_VDD_WARN_BIT   5
`define RSC_SMC_VBAT_WARN_BIT  4
`define RSC_SMC_CORE_IE_BIT    3
`define RSC_SMC_BAT_IE_BIT     2
`define RSC_SMC_UNUSED_VAL     2'h0
`define RSC_SMC_ON_RST         1'h1
`define RSC_SMC_CORE_IE_RST    1'h1
`define RSC_SMC_BAT_IE_RST     1'h0

// ==========================================================
// reset_cause_register fields
`define RSC_RC_RTC_BIT         7
`define RSC_RC_CMP_BIT         5
`define RSC_RC_SW_BIT          4
`define RSC_RC_MCD_BIT         2
`define RSC_RC_POR_BIT         1
`define RSC_RC_MCD_EN_RST      1'h0
`define RSC_RC_SEL_RST         1'h1

// ==========================================================
// Timing
`define RSC_CLK_PERIOD_NS      10
`define RSC_MCD_TIME_US        100
`define RSC_WDT_DIV            4'hC
`define RSC_WDT_LIMIT          8'hFF
`define RSC_RST_HOLD_CYC       4'h8
`define RSC_SYNC_INIT          8'h1F

`endif

// ==== include/rsc_pkg.sv ====
// Types shared by the reset source controller
package rsc_pkg;

	// Cause vector, field order matches reset_cause_register bits 7..0
	typedef struct packed {
		logic rtc;
		logic ferr;
		logic cmp;
		logic sw;
		logic wdt;
		logic missing_clock_detector;
		logic por;
		logic pin;
	} rsc_cause_type;

	// One flash access attempt as reported by the core, valid for one cycle
	typedef struct packed {
		logic wr_erase;
		logic prog_store_write_en;
		logic table_read;
		logic branch;
		logic above_lock;
		logic security_block;
	} rsc_flash_type;

	typedef enum logic [2:0] {
		RSC_RUN  = 3'b001,
		RSC_HOLD = 3'b010,
		RSC_EXIT = 3'b100
	} rsc_state_type;

endpackage

// ==== src/rsc_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps

module rsc_sync #(
	parameter int          W    = 8,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end else begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A change is taken only when stages two and three agree
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_sync <= INIT;
		end else begin
			o_sync <= (s2 & s3) | (o_sync & (s2 | s3));
		end
	end

endmodule

// ==== src/rsc_top.sv ====
// Reset source controller: cause capture, source enables and supply monitor control
`timescale 1ns/10ps
`include "rsc_cfg.svh"

// Functional notes
// - Monitor on bit; resets only when also selected
// - Bit 6 shows live core supply above reset
// - Bit 5 shows core supply above warning
// - Bit 4 shows battery above warning, variant-dependent
// - Bit 3 core warning interrupt enable, resets 1
// - Bit 2 battery warning interrupt enable, resets 0
// - Bits 1:0 read zero, writes ignored
// - Low reset pin forces reset, also asleep
// - Pin reset sets flag bit 0 on exit
// - Clock stuck beyond 100 us causes reset
// - Bit 2 enables detector; reads its flag
// - Detector reset off during low power, restored
// - Non-supply resets leave reset pin undriven
// - Bit 5 selects comparator reset; reads flag
// - Comparator reset in sleep only if wake-enabled
// - Watchdog on at divide-by-12 after reset
// - Watchdog reset off during low power, restored
// - Illegal flash accesses cause system reset
// - Flash error reset sets flag bit 6
// - Bit 7 selects clock-fail or alarm reset
// - Writing bit 4 forces reset; reads back 1
// - Selected monitor holds core, drives pin low
module rsc_top
	import rsc_pkg::*;
#(
	parameter int MCD_CYC        = (`RSC_MCD_TIME_US * 1000) / `RSC_CLK_PERIOD_NS,
	parameter bit HAS_VBAT_WARN  = 1'b1
) (
	input  wire logic          I_CLK,
	input  wire logic          I_NRST,
	input  wire logic [7:0]    I_SFR_ADDR,
	input  wire logic          I_SFR_WR,
	input  wire logic          I_SFR_RD,
	input  wire logic [7:0]    I_SFR_WDATA,
	output logic      [7:0]    O_SFR_RDATA,
	input  wire logic          I_RST_PIN_N,
	output logic               O_RST_PIN_OUT,
	output logic               O_RST_PIN_OE,
	input  wire logic          I_VDD_ABOVE_RST,
	input  wire logic          I_VDD_ABOVE_WARN,
	input  wire logic          I_VBAT_ABOVE_WARN,
	input  wire logic          I_CMP_OUT,
	input  wire logic          I_CMP_WAKE_EN,
	input  wire logic          I_RTC_OSC_FAIL,
	input  wire logic          I_RTC_ALARM,
	input  wire logic          I_CLK_SENSE,
	input  wire logic          I_LOW_POWER,
	input  wire logic          I_WDT_KICK,
	input  wire logic          I_WDT_DISABLE,
	input  wire rsc_flash_type I_FLASH,
	output logic               O_SYS_RST,
	output logic               O_SUPPLY_MONITOR_ON,
	output logic               O_CORE_WARN_IRQ,
	output logic               O_BAT_WARN_IRQ
);

	// ==========================================================
	// Input synchronisation
	logic [7:0]    sync_q;
	logic          pin_n;
	logic          vdd_rst_ok;
	logic          vdd_warn_ok;
	logic          vbat_warn_ok;
	logic          cmp_high;
	logic          rtc_fail;
	logic          rtc_alarm;
	logic          clk_sense;

	rsc_sync #(
		.W    (8),
		.INIT (`RSC_SYNC_INIT)
	) u_sync (
		.i_clk   (I_CLK),
		.i_nrst  (I_NRST),
		.i_async ({I_CLK_SENSE, I_RTC_ALARM, I_RTC_OSC_FAIL, I_CMP_OUT,
		           I_VBAT_ABOVE_WARN, I_VDD_ABOVE_WARN, I_VDD_ABOVE_RST, I_RST_PIN_N}),
		.o_sync  (sync_q)
	);

	assign pin_n        = sync_q[0];
	assign vdd_rst_ok   = sync_q[1];
	assign vdd_warn_ok  = sync_q[2];
	assign vbat_warn_ok = sync_q[3] & HAS_VBAT_WARN;
	assign cmp_high     = sync_q[4];
	assign rtc_fail     = sync_q[5];
	assign rtc_alarm    = sync_q[6];
	assign clk_sense    = sync_q[7];

	// ==========================================================
	// Control state
	rsc_state_type state;
	rsc_state_type next_state;
	rsc_cause_type cause;
	rsc_cause_type flags;
	rsc_cause_type req;
	logic          monitor_on;
	logic          monitor_select;
	logic          core_ie;
	logic          bat_ie;
	logic          mcd_en;
	logic          cmp_en;
	logic          rtc_en;
	logic          sw_req;
	logic          wdt_en;
	logic [3:0]    wdt_div;
	logic [7:0]    wdt_cnt;
	logic [15:0]   mcd_cnt;
	logic          clk_sense_d;
	logic [3:0]    hold_cnt;
	logic          run;
	logic          wr_smc;
	logic          wr_cause;
	logic          supply_fail;
	logic          src_active;
	logic [3:0]    drive_echo;
	logic          pin_ignore;

	assign run      = (state == RSC_RUN);
	assign wr_smc   = I_SFR_WR && run && (I_SFR_ADDR == `RSC_ADDR_SUPPLY_CTRL);
	assign wr_cause = I_SFR_WR && run && (I_SFR_ADDR == `RSC_ADDR_CAUSE);

	// ==========================================================
	// Reset requests
	// Power-fail reset is suspended in sleep so RAM survives a dying battery
	assign supply_fail = monitor_on && monitor_select && !vdd_rst_ok && !I_LOW_POWER;

	always_comb begin
		req      = '0;
		req.pin  = !pin_n && !pin_ignore;
		req.por  = supply_fail;
		req.missing_clock_detector  = mcd_en && !I_LOW_POWER && (mcd_cnt > 16'(MCD_CYC));
		req.cmp  = cmp_en && !cmp_high && (!I_LOW_POWER || I_CMP_WAKE_EN);
		req.wdt  = wdt_en && !I_LOW_POWER && (wdt_cnt == `RSC_WDT_LIMIT);
		req.ferr = (I_FLASH.wr_erase && I_FLASH.prog_store_write_en && I_FLASH.above_lock) ||
		           (I_FLASH.table_read && I_FLASH.above_lock) ||
		           (I_FLASH.branch && I_FLASH.above_lock) ||
		           I_FLASH.security_block ||
		           (I_FLASH.wr_erase && !monitor_on);
		req.rtc  = rtc_en && (rtc_fail || rtc_alarm);
		req.sw   = sw_req;
	end

	// Fixed priority when several sources coincide
	function automatic rsc_cause_type pick(input rsc_cause_type r);
		rsc_cause_type p;
		p = '0;
		if (r.por) begin
			p.por = 1'b1;
		end else if (r.pin) begin
			p.pin = 1'b1;
		end else if (r.missing_clock_detector) begin
			p.missing_clock_detector = 1'b1;
		end else if (r.cmp) begin
			p.cmp = 1'b1;
		end else if (r.wdt) begin
			p.wdt = 1'b1;
		end else if (r.ferr) begin
			p.ferr = 1'b1;
		end else if (r.rtc) begin
			p.rtc = 1'b1;
		end else if (r.sw) begin
			p.sw = 1'b1;
		end
		return p;
	endfunction

	// ==========================================================
	// Reset sequencer
	// Level sources keep the core held until they go away
	assign src_active = (!pin_n && !pin_ignore) || supply_fail || (cmp_en && !cmp_high) ||
	                    (cause.por && !vdd_rst_ok);

	always_comb begin
		case (state)
			RSC_RUN: begin
				next_state = (|req) ? RSC_HOLD : RSC_RUN;
			end
			RSC_HOLD: begin
				next_state = (!src_active && hold_cnt == `RSC_RST_HOLD_CYC - 4'h1) ? RSC_EXIT : RSC_HOLD;
			end
			RSC_EXIT: begin
				next_state = RSC_RUN;
			end
			default: begin
				next_state = RSC_HOLD;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state <= RSC_HOLD;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			hold_cnt <= 4'h0;
		end else if (state != RSC_HOLD || src_active) begin
			hold_cnt <= 4'h0;
		end else if (hold_cnt != `RSC_RST_HOLD_CYC - 4'h1) begin
			hold_cnt <= hold_cnt + 4'h1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cause <= '{por: 1'b1, default: 1'b0};
		end else if (run && (|req)) begin
			cause <= pick(req);
		end
	end

	// Flags change only on the way out of reset, so no clear can race a set
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			flags <= '0;
		end else if (state == RSC_EXIT) begin
			flags <= cause;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_SYS_RST     <= 1'b1;
			O_RST_PIN_OE  <= 1'b1;
			O_RST_PIN_OUT <= 1'b0;
		end else begin
			O_SYS_RST     <= (next_state != RSC_RUN);
			// Only power-on and power-fail resets pull the pin
			O_RST_PIN_OE  <= (next_state == RSC_HOLD) && (run ? req.por : cause.por);
			O_RST_PIN_OUT <= 1'b0;
		end
	end

	// Our own pull comes back through the synchroniser; ignore the pin until that echo has passed.
	// Limitation: a press during a supply hold is not told apart from our own drive.
	assign pin_ignore = O_RST_PIN_OE || (|drive_echo);

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			drive_echo <= 4'hF;
		end else begin
			drive_echo <= {drive_echo[2:0], O_RST_PIN_OE};
		end
	end

	// ==========================================================
	// Software-writable enables
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			monitor_on <= `RSC_SMC_ON_RST;
			core_ie    <= `RSC_SMC_CORE_IE_RST;
			bat_ie     <= `RSC_SMC_BAT_IE_RST;
		end else if (state == RSC_EXIT && cause.por) begin
			monitor_on <= 1'b1;
		end else if (wr_smc) begin
			monitor_on <= I_SFR_WDATA[`RSC_SMC_ON_BIT];
			core_ie    <= I_SFR_WDATA[`RSC_SMC_CORE_IE_BIT];
			bat_ie     <= I_SFR_WDATA[`RSC_SMC_BAT_IE_BIT];
		end
	end

	// Supply selection survives all resets except power-on and power-fail, which set it; comparator and RTC selections clear on every reset
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			monitor_select <= `RSC_RC_SEL_RST;
			mcd_en         <= `RSC_RC_MCD_EN_RST;
			cmp_en         <= 1'b0;
			rtc_en         <= 1'b0;
		end else if (state == RSC_EXIT) begin
			monitor_select <= monitor_select | cause.por;
			cmp_en         <= 1'b0;
			rtc_en         <= 1'b0;
		end else if (wr_cause) begin
			monitor_select <= I_SFR_WDATA[`RSC_RC_POR_BIT];
			mcd_en         <= I_SFR_WDATA[`RSC_RC_MCD_BIT];
			cmp_en         <= I_SFR_WDATA[`RSC_RC_CMP_BIT];
			rtc_en         <= I_SFR_WDATA[`RSC_RC_RTC_BIT];
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sw_req <= 1'b0;
		end else begin
			sw_req <= wr_cause && I_SFR_WDATA[`RSC_RC_SW_BIT];
		end
	end

	// ==========================================================
	// Missing clock detector: cycles since the sensed clock last moved
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			clk_sense_d <= 1'b0;
			mcd_cnt     <= 16'h0000;
		end else begin
			clk_sense_d <= clk_sense;
			// The clock may stop in low power; restart the count so waking does not fire at once
			if (!run || I_LOW_POWER || clk_sense != clk_sense_d) begin
				mcd_cnt <= 16'h0000;
			end else if (mcd_cnt <= 16'(MCD_CYC)) begin
				mcd_cnt <= mcd_cnt + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Watchdog, ticking at the system clock divided by 12
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			wdt_en  <= 1'b1;
			wdt_div <= 4'h0;
			wdt_cnt <= 8'h00;
		end else if (!run) begin
			wdt_en  <= 1'b1;
			wdt_div <= 4'h0;
			wdt_cnt <= 8'h00;
		end else begin
			if (I_WDT_DISABLE) begin
				wdt_en <= 1'b0;
			end
			if (I_WDT_KICK || !wdt_en || I_LOW_POWER) begin
				wdt_div <= 4'h0;
				wdt_cnt <= 8'h00;
			end else if (wdt_div == `RSC_WDT_DIV - 4'h1) begin
				wdt_div <= 4'h0;
				if (wdt_cnt != `RSC_WDT_LIMIT) begin
					wdt_cnt <= wdt_cnt + 8'h01;
				end
			end else begin
				wdt_div <= wdt_div + 4'h1;
			end
		end
	end

	// ==========================================================
	// Register reads and status outputs
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_SFR_RDATA <= 8'h00;
		end else if (I_SFR_RD) begin
			case (I_SFR_ADDR)
				`RSC_ADDR_SUPPLY_CTRL: begin
					O_SFR_RDATA <= {monitor_on, vdd_rst_ok, vdd_warn_ok, vbat_warn_ok,
					                core_ie, bat_ie, `RSC_SMC_UNUSED_VAL};
				end
				`RSC_ADDR_CAUSE: begin
					O_SFR_RDATA <= flags;
				end
				default: begin
					O_SFR_RDATA <= 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_SUPPLY_MONITOR_ON <= 1'b1;
			O_CORE_WARN_IRQ     <= 1'b0;
			O_BAT_WARN_IRQ      <= 1'b0;
		end else begin
			O_SUPPLY_MONITOR_ON <= monitor_on;
			O_CORE_WARN_IRQ     <= core_ie && !vdd_warn_ok;
			O_BAT_WARN_IRQ      <= bat_ie && HAS_VBAT_WARN && !vbat_warn_ok;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);

	sw_force_a: assert property (wr_cause && I_SFR_WDATA[`RSC_RC_SW_BIT] |-> ##2 O_SYS_RST)
		else $error("software force did not reset");
	pin_reset_a: assert property (run && !pin_n && !pin_ignore |=> state == RSC_HOLD ##1 O_SYS_RST)
		else $error("pin reset not taken");
	pin_undriven_a: assert property (O_RST_PIN_OE |-> cause.por || $past(supply_fail))
		else $error("reset pin driven by wrong source");
	flag_latch_a: assert property (state == RSC_EXIT |=> flags == $past(cause) && $onehot(flags))
		else $error("cause flags not latched");
	mcd_sleep_a: assert property (I_LOW_POWER |-> !req.missing_clock_detector)
		else $error("missing clock reset in low power");
	wdt_sleep_a: assert property (I_LOW_POWER |-> !req.wdt)
		else $error("watchdog reset in low power");
	cmp_gate_a: assert property (req.cmp |-> !cmp_high && (!I_LOW_POWER || I_CMP_WAKE_EN))
		else $error("comparator reset gating wrong");
	unused_bits_a: assert property (I_SFR_RD && I_SFR_ADDR == `RSC_ADDR_SUPPLY_CTRL |=> O_SFR_RDATA[1:0] == 2'h0)
		else $error("unused bits not zero");
	wdt_after_a: assert property (state == RSC_EXIT |=> wdt_en && wdt_cnt == 8'h00)
		else $error("watchdog not armed after reset");
	monitor_gate_a: assert property (req.por |-> monitor_on && monitor_select)
		else $error("supply reset without selection");

	sw_reset_c: cover property (state == RSC_EXIT && cause.sw);
	pin_reset_c: cover property (state == RSC_EXIT && cause.pin);
	supply_reset_c: cover property (O_RST_PIN_OE ##1 !O_RST_PIN_OE);
	flash_reset_c: cover property (state == RSC_EXIT && cause.ferr);

endmodule

// ==== sim/rsc_far_side.sv ====
// Far-side model: reset pin network and comparator front end
`timescale 1ns/10ps

module rsc_far_side (
	input  wire logic        i_press,
	input  wire logic        i_dev_oe,
	input  wire logic        i_dev_out,
	input  wire logic [11:0] i_noninv_mv,
	input  wire logic [11:0] i_inv_mv,
	output logic             o_pin_n,
	output logic             o_cmp_out
);
	// ==========================================================
	// Reset pin
	// Pull-up holds the pin high unless the board or the device pulls it low
	assign o_pin_n = ~i_press & ~(i_dev_oe & ~i_dev_out);

	// ==========================================================
	// Comparator
	// Output low means the non-inverting input is not above the inverting one
	assign o_cmp_out = (i_noninv_mv > i_inv_mv);
endmodule

// ==== sim/rsc_top_tb.sv ====
// Self-checking bench for the reset source controller
`timescale 1ns/10ps

module rsc_top_tb;
	import rsc_pkg::*;

	logic          clk, nrst, sfr_wr, sfr_rd, press, vdd_rst, vdd_warn, vbat_warn, wake;
	logic          osc_fail, alarm, low_pwr, kick_on, sense_run, wdt_dis;
	logic          sense = 1'b0;
	logic          kick  = 1'b0;
	logic [8:0]    kcnt  = 9'h000;
	logic [7:0]    addr, wdata, rdata;
	logic [11:0]   cp_pos, cp_neg;
	rsc_flash_type flash;
	logic          pin_n, pin_out, pin_oe, cmp_out, sys_rst, mon_on, core_irq, bat_irq;
	int            n_mismatch, checked;

	// MCD_CYC shortened so a stuck clock is seen after 40 cycles
	rsc_top #(.MCD_CYC(40)) dut (.I_CLK(clk), .I_NRST(nrst), .I_SFR_ADDR(addr), .I_SFR_WR(sfr_wr),
		.I_SFR_RD(sfr_rd), .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .I_RST_PIN_N(pin_n),
		.O_RST_PIN_OUT(pin_out), .O_RST_PIN_OE(pin_oe), .I_VDD_ABOVE_RST(vdd_rst),
		.I_VDD_ABOVE_WARN(vdd_warn), .I_VBAT_ABOVE_WARN(vbat_warn), .I_CMP_OUT(cmp_out),
		.I_CMP_WAKE_EN(wake), .I_RTC_OSC_FAIL(osc_fail), .I_RTC_ALARM(alarm), .I_CLK_SENSE(sense),
		.I_LOW_POWER(low_pwr), .I_WDT_KICK(kick), .I_WDT_DISABLE(wdt_dis), .I_FLASH(flash),
		.O_SYS_RST(sys_rst), .O_SUPPLY_MONITOR_ON(mon_on), .O_CORE_WARN_IRQ(core_irq),
		.O_BAT_WARN_IRQ(bat_irq));

	rsc_far_side far (.i_press(press), .i_dev_oe(pin_oe), .i_dev_out(pin_out), .i_noninv_mv(cp_pos),
		.i_inv_mv(cp_neg), .o_pin_n(pin_n), .o_cmp_out(cmp_out));

	// ==========================================================
	// Clock, clock image and watchdog service
	initial clk = 1'b0;
	always #5 clk = ~clk;
	always @(negedge clk) begin
		// Clock image moves every four cycles so the input filter sees each level settle
		if (sense_run && kcnt[1:0] == 2'h0) sense <= ~sense;
		kcnt <= kcnt + 9'h001;
		kick <= kick_on && (kcnt == 9'h000);
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		chk(nm, e, rdata);
	endtask

	// Waits a bounded time for the core to enter reset, then checks the pin drive
	task automatic see_rst(input string nm, input int lim, input logic oe);
		int n;
		n = 0;
		while (sys_rst !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk({nm, " reset"}, 8'h01, {7'h00, sys_rst});
		chk({nm, " pin drive"}, {7'h00, oe}, {7'h00, pin_oe});
		chk({nm, " pin out"}, 8'h00, {7'h00, pin_out});
	endtask

	task automatic no_rst(input string nm, input int cyc);
		repeat (cyc) begin
			@(negedge clk);
			if (sys_rst !== 1'b0) begin
				n_mismatch++;
				$display("BAD %s expected 0 seen %b", nm, sys_rst);
			end
		end
		checked++;
	endtask

	task automatic free_wait(input string nm, input logic [7:0] cause);
		int n;
		n = 0;
		while (sys_rst !== 1'b0 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk({nm, " release"}, 8'h00, {7'h00, sys_rst});
		rd({nm, " cause"}, 8'hEF, cause);
		$display("test %s done", nm);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_status;
		rd("ctrl reset", 8'hFF, 8'hF8);
		chk("monitor on", 8'h01, {7'h00, mon_on});
		wr(8'hFF, 8'h07);
		rd("ctrl write", 8'hFF, 8'h74);
		chk("monitor off", 8'h00, {7'h00, mon_on});
		vdd_warn = 1'b0;
		vbat_warn = 1'b0;
		repeat (6) @(negedge clk);
		rd("ctrl warn", 8'hFF, 8'h44);
		chk("bat irq", 8'h01, {7'h00, bat_irq});
		chk("core irq off", 8'h00, {7'h00, core_irq});
		wr(8'hFF, 8'h88);
		repeat (2) @(negedge clk);
		chk("core irq", 8'h01, {7'h00, core_irq});
		chk("bat irq off", 8'h00, {7'h00, bat_irq});
		vdd_warn = 1'b1;
		vbat_warn = 1'b1;
		$display("test status done");
	endtask

	task automatic t_soft;
		wr(8'hEF, 8'h12);
		see_rst("soft", 10, 1'b0);
		free_wait("soft", 8'h10);
	endtask

	task automatic t_pin;
		low_pwr = 1'b1;
		press = 1'b1;
		see_rst("pin", 10, 1'b0);
		press = 1'b0;
		low_pwr = 1'b0;
		free_wait("pin", 8'h01);
	endtask

	task automatic t_mcd;
		wr(8'hEF, 8'h06);
		low_pwr = 1'b1;
		sense_run = 1'b0;
		no_rst("mcd asleep", 100);
		sense_run = 1'b1;
		low_pwr = 1'b0;
		repeat (5) @(negedge clk);
		sense_run = 1'b0;
		no_rst("mcd early", 30);
		see_rst("mcd", 40, 1'b0);
		sense_run = 1'b1;
		free_wait("mcd", 8'h04);
	endtask

	task automatic t_cmp;
		wr(8'hEF, 8'h22);
		low_pwr = 1'b1;
		cp_pos = 12'h032;
		no_rst("cmp asleep", 30);
		wake = 1'b1;
		see_rst("cmp", 10, 1'b0);
		low_pwr = 1'b0;
		wake = 1'b0;
		cp_pos = 12'h0C8;
		free_wait("cmp", 8'h20);
	endtask

	task automatic t_wdt;
		kick_on = 1'b0;
		no_rst("wdt early", 2500);
		see_rst("wdt", 700, 1'b0);
		kick_on = 1'b1;
		free_wait("wdt", 8'h08);
		@(negedge clk);
		wdt_dis = 1'b1;
		@(negedge clk);
		wdt_dis = 1'b0;
		kick_on = 1'b0;
		no_rst("wdt off", 3200);
		kick_on = 1'b1;
		$display("test wdt off done");
	endtask

	task automatic t_flash;
		rsc_flash_type f [5];
		f = '{6'b110010, 6'b001010, 6'b000110, 6'b001001, 6'b110000};
		for (int i = 0; i < 5; i++) begin
			if (i == 4) wr(8'hFF, 8'h08);
			@(negedge clk);
			flash = f[i];
			@(negedge clk);
			flash = '0;
			see_rst("flash", 10, 1'b0);
			free_wait("flash", 8'h40);
		end
		wr(8'hFF, 8'h88);
	endtask

	task automatic t_rtc;
		for (int i = 0; i < 2; i++) begin
			wr(8'hEF, 8'h82);
			low_pwr = 1'b1;
			if (i == 0) alarm = 1'b1;
			else osc_fail = 1'b1;
			see_rst("rtc", 10, 1'b0);
			alarm = 1'b0;
			osc_fail = 1'b0;
			low_pwr = 1'b0;
			free_wait("rtc", 8'h80);
		end
	endtask

	task automatic t_supply;
		wr(8'hEF, 8'h00);
		vdd_rst = 1'b0;
		no_rst("supply deselected", 30);
		rd("supply status", 8'hFF, 8'hB8);
		vdd_rst = 1'b1;
		repeat (6) @(negedge clk);
		wr(8'hEF, 8'h02);
		vdd_rst = 1'b0;
		see_rst("supply", 10, 1'b1);
		vdd_rst = 1'b1;
		free_wait("supply", 8'h02);
	endtask

	// ==========================================================
	// Main sequence and hang guard
	initial begin
		{nrst, sfr_wr, sfr_rd, press, wake, osc_fail, alarm, low_pwr, wdt_dis} = '0;
		{vdd_rst, vdd_warn, vbat_warn, kick_on, sense_run} = '1;
		{addr, wdata} = '0;
		cp_pos = 12'h0C8;
		cp_neg = 12'h064;
		flash = '0;
		n_mismatch = 0;
		checked = 0;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		free_wait("power on", 8'h02);
		t_status();
		t_soft();
		t_pin();
		t_mcd();
		t_cmp();
		t_wdt();
		t_flash();
		t_rtc();
		t_supply();
		end_sim();
	end

	// Budget of about 50k cycles, several times the expected run
	initial begin
		#500000;
		n_mismatch++;
		end_sim();
	end
endmodule
